// >>> rtl/umsb_regs.vh
`ifndef UMSB_REGS_VH
`define UMSB_REGS_VH
// modem status bit positions
`define UMSB_MS_DCTS      0
`define UMSB_MS_DDSR      1
`define UMSB_MS_RING_TRAILING_EDGE_FLAG      2
`define UMSB_MS_DDCD      3
`define UMSB_MS_CTS       4
`define UMSB_MS_DSR       5
`define UMSB_MS_RI        6
`define UMSB_MS_DCD       7
// modem control bit positions
`define UMSB_MC_DTR       0
`define UMSB_MC_RTS       1
`define UMSB_MC_OUT_ONE   2
`define UMSB_MC_OUT_TWO   3
`define UMSB_MC_LOOP      4
// reset values
`define UMSB_MS_DELTA_RST 4'h0
`define UMSB_MC_RST       5'h00
`define UMSB_DIV_RST      16'h0001
`define UMSB_DIV_LO_RST   8'h01
`define UMSB_DIV_HI_RST   8'h00
`define UMSB_FLAG_RST     1'b0
`define UMSB_PIN_IDLE     4'hf
// reference clock ceiling for the divider, hertz
`define UMSB_REF_MAX_HZ   8000000
`define UMSB_OVERSAMPLE   16
`endif

// >>> rtl/umsb_baud_div.v
`timescale 1ns/10ps
module umsb_baud_div #(
  parameter integer W = 16
) (
  // clock and reset
  input  wire         i_ref_clk,
  input  wire         i_rst,
  // divisor control
  input  wire [W-1:0] i_divisor,
  input  wire         i_load,
  // 16x sample enable
  output reg          o_tick
);
  reg [W-1:0] cnt_q;

  // zero divisor is treated as one so the enable never stalls
  always @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      cnt_q  <= {W{1'b0}};
      o_tick <= 1'b0;
    end
    else if (i_load)
    begin
      cnt_q  <= i_divisor;
      o_tick <= 1'b0;
    end
    else if (cnt_q <= {{(W-1){1'b0}}, 1'b1})
    begin
      cnt_q  <= i_divisor;
      o_tick <= 1'b1;
    end
    else
    begin
      cnt_q  <= cnt_q - {{(W-1){1'b0}}, 1'b1};
      o_tick <= 1'b0;
    end
  end
endmodule

// >>> rtl/umsb_modem_status.v
`timescale 1ns/10ps
`include "umsb_regs.vh"
module umsb_modem_status #(
  parameter integer DIV_W = 16
) (
  // clock and reset
  input  wire       i_ref_clk,
  input  wire       i_rst,
  // cpu side
  input  wire       i_status_rd,
  input  wire       i_ctrl_wr,
  input  wire [4:0] i_ctrl_wdata,
  input  wire       i_div_lo_wr,
  input  wire       i_div_hi_wr,
  input  wire [7:0] i_div_wdata,
  input  wire       i_modem_irq_enable,
  output reg  [7:0] o_modem_line_status,
  output wire [4:0] o_modem_control_reg,
  output wire [15:0] o_divisor,
  output wire       o_modem_irq,
  // modem pins, active low
  input  wire       i_cts_n,
  input  wire       i_dsr_n,
  input  wire       i_ri_n,
  input  wire       i_dcd_n,
  output wire       o_dtr_n,
  output wire       o_rts_n,
  output wire       o_aux_output_one_n,
  output wire       o_aux_output_two_n,
  // baud enable
  output wire       o_sample_tick
);
  reg  [3:0] pin_s1_q;
  reg  [3:0] pin_s2_q;
  reg  [3:0] prev_q;
  wire [3:0] delta_q;
  reg        flag_cts_q;
  reg        flag_dsr_q;
  reg        flag_ri_q;
  reg        flag_dcd_q;
  reg        pend_cts_q;
  reg        pend_dsr_q;
  reg        pend_ri_q;
  reg        pend_dcd_q;
  reg  [3:0] pin_out_q;
  reg  [4:0] ctrl_q;
  reg  [7:0] div_lo_q;
  reg  [7:0] div_hi_q;
  reg        rd_q;
  reg        primed_q;
  reg  [3:0] cur;
  wire       loop_mode_enable;
  wire       chg_cts;
  wire       chg_dsr;
  wire       chg_ri;
  wire       chg_dcd;
  wire       rd_end;

  assign loop_mode_enable    = ctrl_q[`UMSB_MC_LOOP];
  assign o_modem_control_reg = ctrl_q;
  assign o_divisor           = {div_hi_q, div_lo_q};
  // pins held inactive while looped back; registered so they cannot glitch
  always @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      pin_out_q <= `UMSB_PIN_IDLE;
    end
    else
    begin
      pin_out_q[0] <= loop_mode_enable | ~ctrl_q[`UMSB_MC_DTR];
      pin_out_q[1] <= loop_mode_enable | ~ctrl_q[`UMSB_MC_RTS];
      pin_out_q[2] <= loop_mode_enable | ~ctrl_q[`UMSB_MC_OUT_ONE];
      pin_out_q[3] <= loop_mode_enable | ~ctrl_q[`UMSB_MC_OUT_TWO];
    end
  end
  assign o_dtr_n            = pin_out_q[0];
  assign o_rts_n            = pin_out_q[1];
  assign o_aux_output_one_n = pin_out_q[2];
  assign o_aux_output_two_n = pin_out_q[3];

  // pins arrive asynchronously: two flops before use
  always @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      pin_s1_q <= 4'hf;
      pin_s2_q <= 4'hf;
    end
    else
    begin
      pin_s1_q <= {i_dcd_n, i_ri_n, i_dsr_n, i_cts_n};
      pin_s2_q <= pin_s1_q;
    end
  end

  // active-high source order: cts, dsr, ri, dcd
  always @*
  begin
    if (loop_mode_enable)
    begin
      cur = {ctrl_q[`UMSB_MC_OUT_TWO], ctrl_q[`UMSB_MC_OUT_ONE],
             ctrl_q[`UMSB_MC_DTR], ctrl_q[`UMSB_MC_RTS]};
    end
    else
    begin
      cur = ~pin_s2_q;
    end
  end

  // first sample after reset has no history, so it raises nothing
  assign chg_cts = primed_q & (prev_q[0] ^ cur[0]);
  assign chg_dsr = primed_q & (prev_q[1] ^ cur[1]);
  // ri counts only the trailing edge of the ring, active level going away
  assign chg_ri  = primed_q & prev_q[2] & ~cur[2];
  assign chg_dcd = primed_q & (prev_q[3] ^ cur[3]);
  assign rd_end = rd_q & ~i_status_rd;

  // history of the selected source and of the read strobe
  always @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      prev_q   <= 4'h0;
      primed_q <= 1'b0;
      rd_q     <= 1'b0;
    end
    else
    begin
      prev_q   <= cur;
      primed_q <= 1'b1;
      rd_q     <= i_status_rd;
    end
  end

  // flags hold steady while the cpu samples them; changes wait as pending, then set only flags that were clear
  always @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      flag_cts_q <= `UMSB_FLAG_RST;
      pend_cts_q <= `UMSB_FLAG_RST;
    end
    else if (i_status_rd)
    begin
      pend_cts_q <= pend_cts_q | chg_cts;
    end
    else if (rd_end)
    begin
      flag_cts_q <= (pend_cts_q | chg_cts) & ~flag_cts_q;
      pend_cts_q <= `UMSB_FLAG_RST;
    end
    else
    begin
      flag_cts_q <= flag_cts_q | chg_cts;
    end
  end

  always @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      flag_dsr_q <= `UMSB_FLAG_RST;
      pend_dsr_q <= `UMSB_FLAG_RST;
    end
    else if (i_status_rd)
    begin
      pend_dsr_q <= pend_dsr_q | chg_dsr;
    end
    else if (rd_end)
    begin
      flag_dsr_q <= (pend_dsr_q | chg_dsr) & ~flag_dsr_q;
      pend_dsr_q <= `UMSB_FLAG_RST;
    end
    else
    begin
      flag_dsr_q <= flag_dsr_q | chg_dsr;
    end
  end

  always @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      flag_ri_q <= `UMSB_FLAG_RST;
      pend_ri_q <= `UMSB_FLAG_RST;
    end
    else if (i_status_rd)
    begin
      pend_ri_q <= pend_ri_q | chg_ri;
    end
    else if (rd_end)
    begin
      flag_ri_q <= (pend_ri_q | chg_ri) & ~flag_ri_q;
      pend_ri_q <= `UMSB_FLAG_RST;
    end
    else
    begin
      flag_ri_q <= flag_ri_q | chg_ri;
    end
  end

  always @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      flag_dcd_q <= `UMSB_FLAG_RST;
      pend_dcd_q <= `UMSB_FLAG_RST;
    end
    else if (i_status_rd)
    begin
      pend_dcd_q <= pend_dcd_q | chg_dcd;
    end
    else if (rd_end)
    begin
      flag_dcd_q <= (pend_dcd_q | chg_dcd) & ~flag_dcd_q;
      pend_dcd_q <= `UMSB_FLAG_RST;
    end
    else
    begin
      flag_dcd_q <= flag_dcd_q | chg_dcd;
    end
  end

  assign delta_q = {flag_dcd_q, flag_ri_q, flag_dsr_q, flag_cts_q};

  // line half from the selected source, flag half from registers
  always @*
  begin
    o_modem_line_status = 8'h00;
    o_modem_line_status[`UMSB_MS_DCTS] = flag_cts_q;
    o_modem_line_status[`UMSB_MS_DDSR] = flag_dsr_q;
    o_modem_line_status[`UMSB_MS_RING_TRAILING_EDGE_FLAG] = flag_ri_q;
    o_modem_line_status[`UMSB_MS_DDCD] = flag_dcd_q;
    o_modem_line_status[`UMSB_MS_CTS]  = cur[0];
    o_modem_line_status[`UMSB_MS_DSR]  = cur[1];
    o_modem_line_status[`UMSB_MS_RI]   = cur[2];
    o_modem_line_status[`UMSB_MS_DCD]  = cur[3];
  end

  assign o_modem_irq = i_modem_irq_enable & (|delta_q);

  always @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      ctrl_q <= `UMSB_MC_RST;
    end
    else if (i_ctrl_wr)
    begin
      ctrl_q <= i_ctrl_wdata;
    end
  end

  // latches start at a divisor of one so the enable runs from reset
  always @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      div_lo_q <= `UMSB_DIV_LO_RST;
      div_hi_q <= `UMSB_DIV_HI_RST;
    end
    else
    begin
      if (i_div_lo_wr)
      begin
        div_lo_q <= i_div_wdata;
      end
      if (i_div_hi_wr)
      begin
        div_hi_q <= i_div_wdata;
      end
    end
  end

  // reload uses latched value next cycle, so delay the load one edge
  reg div_ld_q;
  always @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      div_ld_q <= 1'b0;
    end
    else
    begin
      div_ld_q <= i_div_lo_wr | i_div_hi_wr;
    end
  end

  umsb_baud_div #(
    .W (DIV_W)
  ) umsb_baud_div_inst (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_divisor (o_divisor),
    .i_load    (div_ld_q),
    .o_tick    (o_sample_tick)
  );
endmodule

// >>> testbench/umsb_monitor.sv
`timescale 1ns/10ps
module umsb_monitor (
  // clock and reset
  input wire        i_ref_clk,
  input wire        i_rst,
  // cpu side
  input wire        i_status_rd,
  input wire        i_div_lo_wr,
  input wire        i_div_hi_wr,
  input wire [7:0]  i_div_wdata,
  input wire        i_modem_irq_enable,
  input wire [7:0]  o_modem_line_status,
  input wire [4:0]  o_modem_control_reg,
  input wire [15:0] o_divisor,
  input wire        o_modem_irq,
  // pins and tick
  input wire        i_cts_n,
  input wire        o_sample_tick
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  wire [3:0] dl = o_modem_line_status[3:0];
  wire [4:0] mc = o_modem_control_reg;
  // cycles since the last divisor write, saturating
  reg  [3:0] since_wr;
  always @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
      since_wr <= 4'h0;
    else if (i_div_lo_wr || i_div_hi_wr)
      since_wr <= 4'h0;
    else if (since_wr != 4'hf)
      since_wr <= since_wr + 4'h1;
  end
  AST_IRQ: assert property (o_modem_irq == (i_modem_irq_enable && |dl))
    else $error("irq does not follow delta flags");
  AST_LOOP_MAP: assert property ((mc[4] && $stable(mc))[*4]
    |-> o_modem_line_status[7:4] == {mc[3], mc[2], mc[0], mc[1]})
    else $error("loop line bits wrong");
  AST_LINE_CTS: assert property ((!mc[4] && $stable(i_cts_n))[*4]
    |-> o_modem_line_status[4] == !i_cts_n)
    else $error("cts line bit wrong");
  AST_RD_NOSET: assert property ($past(i_status_rd) |-> (dl & ~$past(dl)) == 0)
    else $error("delta set during read");
  AST_RD_CLR: assert property ($fell(i_status_rd) |=> (dl & $past(dl)) == 0)
    else $error("delta not cleared by read");
  AST_DIV_LO: assert property (i_div_lo_wr |=> o_divisor[7:0] == $past(i_div_wdata))
    else $error("low divisor not written");
  AST_DIV_HI: assert property (i_div_hi_wr |=> o_divisor[15:8] == $past(i_div_wdata))
    else $error("high divisor not written");
  AST_RELOAD: assert property ((i_div_lo_wr || i_div_hi_wr) ##1
    o_divisor == 16'h0004 |-> ##[1:6] o_sample_tick)
    else $error("counter not reloaded");
  AST_PERIOD: assert property (since_wr >= 4'ha &&
    o_divisor == 16'h0004 && $past(o_divisor, 5) == 16'h0004
    |-> o_sample_tick == $past(o_sample_tick, 4))
    else $error("tick period wrong");
  cover property (o_modem_irq);
  cover property ($fell(i_status_rd) && |dl);
  cover property (o_sample_tick && o_divisor == 16'h0004);
endmodule
bind umsb_modem_status umsb_monitor umsb_monitor_inst (.*);

// >>> testbench/umsb_modem_model.sv
`timescale 1ns/10ps
module umsb_modem_model (
  // clock
  input  wire       i_ref_clk,
  // wanted line states, active high: cts dsr ri dcd
  input  wire [3:0] i_active,
  // pins, active low
  output reg  [3:0] o_pins_n
);
  initial o_pins_n = 4'hf;
  // pins move after an edge, unrelated to the sync phase
  always @(posedge i_ref_clk)
    o_pins_n <= ~i_active;
endmodule

// >>> testbench/uart_modem_status_baud_gen_tb.sv
`timescale 1ns/10ps
module uart_modem_status_baud_gen_tb;
  reg         i_ref_clk = 1'b0;
  reg         i_rst = 1'b1;
  reg         rd = 1'b0;
  reg  [2:0]  wr = 3'h0;
  reg  [7:0]  wd = 8'h00;
  reg         ien = 1'b0;
  reg  [3:0]  act = 4'h0;
  wire [7:0]  ms;
  wire [4:0]  mc;
  wire [15:0] dv;
  wire        irq;
  wire        tk;
  wire [3:0]  pn;
  wire [3:0]  on;
  integer     err_count = 0;
  integer     checks_done = 0;
  integer     n;
  always #12.5 i_ref_clk = ~i_ref_clk;
  umsb_modem_model umsb_modem_model_inst (.i_ref_clk(i_ref_clk),
    .i_active(act), .o_pins_n(pn));
  umsb_modem_status umsb_modem_status_inst (.i_ref_clk(i_ref_clk),
    .i_rst(i_rst), .i_status_rd(rd), .i_ctrl_wr(wr[0]),
    .i_ctrl_wdata(wd[4:0]), .i_div_lo_wr(wr[1]), .i_div_hi_wr(wr[2]),
    .i_div_wdata(wd), .i_modem_irq_enable(ien), .o_modem_line_status(ms),
    .o_modem_control_reg(mc), .o_divisor(dv), .o_modem_irq(irq),
    .i_cts_n(pn[0]), .i_dsr_n(pn[1]), .i_ri_n(pn[2]), .i_dcd_n(pn[3]),
    .o_dtr_n(on[0]), .o_rts_n(on[1]), .o_aux_output_one_n(on[2]),
    .o_aux_output_two_n(on[3]), .o_sample_tick(tk));
  task cyc(input integer k);
    repeat (k) @(posedge i_ref_clk);
  endtask
  task chk(input [63:0] nm, input [31:0] e, input [31:0] g);
    begin
      checks_done = checks_done + 1;
      if (g !== e)
      begin
        err_count = err_count + 1;
        $display("CHECK FAILED %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task put(input [2:0] w, input [7:0] d);
    begin
      wr <= w;
      wd <= d;
      cyc(1);
      wr <= 3'h0;
      cyc(6);
    end
  endtask
  task rdms;
    begin
      rd <= 1'b1;
      cyc(2);
      rd <= 1'b0;
      cyc(2);
    end
  endtask
  task ticks(input [31:0] e);
    begin
      n = 0;
      repeat (40)
      begin
        @(negedge i_ref_clk);
        n = n + tk;
      end
      @(posedge i_ref_clk);
      chk("ticks", e, n);
    end
  endtask
  task print_verdict;
    begin
      if (err_count == 0 && checks_done > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  initial
  begin
    cyc(12);
    i_rst <= 1'b0;
    cyc(2);
    chk("reset", 32'h01e00001, {on, mc, dv});
    act <= 4'h3;
    cyc(6);
    chk("masked", 32'h033, {irq, ms});
    ien <= 1'b1;
    cyc(2);
    chk("irq", 32'h133, {irq, ms});
    rdms;
    chk("rdclr", 32'h030, {irq, ms});
    act <= 4'h7;
    cyc(6);
    chk("rifall", 32'h070, {irq, ms});
    act <= 4'h3;
    cyc(6);
    chk("ririse", 32'h134, {irq, ms});
    rdms;
    act <= 4'hb;
    cyc(6);
    chk("dcd", 32'h1b8, {irq, ms});
    rd <= 1'b1;
    act <= 4'h2;
    cyc(8);
    chk("inread", 32'h128, {irq, ms});
    rd <= 1'b0;
    cyc(3);
    chk("pended", 32'h121, {irq, ms});
    rdms;
    put(3'h1, 8'h1a);
    chk("loop", 32'h19b, {irq, ms});
    act <= 4'hf;
    cyc(6);
    chk("pinsoff", 32'h19bf, {irq, ms, on});
    rdms;
    put(3'h1, 8'h0f);
    chk("unloop", 32'h1f20, {irq, ms, on});
    put(3'h2, 8'h04);
    put(3'h4, 8'h40);
    put(3'h4, 8'h00);
    chk("div", 32'h0004, dv);
    ticks(10);
    put(3'h2, 8'h01);
    ticks(40);
    print_verdict;
  end
  initial
  begin
    #100000;
    err_count = err_count + 1;
    print_verdict;
  end
endmodule
